// ### sia_pkg.sv
// Package for the status and interrupt aggregator: offsets, bit positions, reset values and carrier structs.
// Assumes one core clock; every status source outside the block except the asynchronous pins is already on that clock.
package sia_pkg;

  localparam int ADDR_W = 9;

  // Register offsets
  localparam logic [8:0] STATUS_BASE = 9'h0_040;
  localparam logic [8:0] PIN_STATUS_OFS = 9'h0_041;
  localparam logic [8:0] IRQ_SUMMARY_OFS = 9'h0_042;
  localparam logic [8:0] GLOBAL_FN_IRQ_OFS = 9'h0_043;
  localparam logic [8:0] IN_CLK_IRQ_OFS = 9'h0_044;
  localparam logic [8:0] OUT_CLK_IRQ_LO_OFS = 9'h0_045;
  localparam logic [8:0] OUT_CLK_IRQ_HI_OFS = 9'h0_046;
  localparam logic [8:0] SYNTH_PLL_IRQ_OFS = 9'h0_047;
  localparam logic [8:0] SYNTH_PLL_STATUS_OFS = 9'h0_048;
  localparam int STATUS_SPAN = 9;

  // Field positions
  localparam int SUM_OUT_CLK_BIT = 5;
  localparam int SUM_IN_CLK_BIT = 4;
  localparam int SUM_PLL_BIT = 2;
  localparam int SUM_GATE_BIT = 1;
  localparam int SUM_FLAG_BIT = 0;
  localparam int BOOT_DONE_BIT = 7;
  localparam int PIN_SEEN_LSB = 4;
  localparam int PLL_REF_LOW_SEEN_BIT = 7;
  localparam int PLL_REF_LOW_NOW_BIT = 6;
  localparam int PLL_REF_HIGH_SEEN_BIT = 5;
  localparam int PLL_REF_HIGH_NOW_BIT = 4;
  localparam int PLL_LOCK_SEEN_BIT = 3;
  localparam int PLL_LOCKED_NOW_BIT = 2;
  localparam int PLL_REF_SEL_BIT = 0;

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } sia_reg_req_t;

  // Index 3 is the crystal input, 2..0 are inputs 3..1
  typedef struct packed {
    logic [3:0] valid_change_seen;
    logic [3:0] irq_en;
  } sia_in_clk_t;

  // Per output: latched bits {low-speed, start, stop} and their enables
  typedef struct packed {
    logic [9:0][2:0] seen;
    logic [9:0][2:0] irq_en;
  } sia_out_clk_t;

  typedef struct packed {
    logic ref_low_now;
    logic ref_high_now;
    logic locked_now;
    logic ref_sel;
  } sia_pll_status_t;

  typedef struct packed {
    logic ref_low;
    logic ref_high;
    logic lock;
  } sia_pll_irq_en_t;

endpackage

// ### sia_status_irq.sv
// Status and interrupt aggregation: pin levels and change latches, group summaries, global flag, boot flag.
// Assumes pins are asynchronous; host and boot controller requests, clock and PLL status are on i_mclk.
`timescale 1ns/100ps

// What this block does
// - Pin level bits return each pin's raw level, before any inversion.
// - Summary bit 5 is high when any low output-clock group bit is high.
// - Summary bit 4 is high when any input-clock group bit is high.
// - Summary bit 2 is high when the PLL group bit is high.
// - Global gate bit 1 is writable; at 0 no group source sets the flag.
// - Global flag bit 0 is set by any group summary while the gate is set.
// - Global flag is also set by any enabled pin change latch.
// - Requests leave through the registered global flag output and through any pin following the flag.
// - Boot finished bit clears on reset and sets when auto configuration ends.
// - Host writes during auto configuration change nothing.
// - Four pin change enables gate the pin latches onto the global flag.
// - Input-clock bit 3 shows crystal latched change and enable, unlatched.
// - Input-clock bits 2..0 show inputs 3..1 latched change with enable.
// - Output-clock low register bits show outputs 8..1 enabled latched status.
// - Output-clock high register bits 1..0 show outputs 10..9, rest zero.
// - PLL group bit 0 shows any enabled latched PLL status bit.
// - Reference-low latch sets on reference-low rising, write one clears it.
// - Reference-low real-time bit reads 1 while the reference is too slow.
// - Pin change latches set on either edge, clear on a written one.
// - Follow selector addresses 0x40 plus five-bit register, three-bit bit index.
// - Lock latch sets on either lock edge; reference-high latch on its rise.
module sia_status_irq (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // Register port: host, and boot controller during auto configuration
  input wire sia_pkg::sia_reg_req_t i_host_req,
  input wire sia_pkg::sia_reg_req_t i_boot_req,
  input wire logic i_autocfg_busy,
  input wire logic i_boot_done,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Pins and follow selectors
  input wire logic [3:0] i_pin_level,
  input wire logic [3:0][7:0] i_pin_follow_select,
  output logic [3:0] o_pin_follow_bit,
  // Status sources
  input wire sia_pkg::sia_in_clk_t i_in_clk,
  input wire sia_pkg::sia_out_clk_t i_out_clk,
  input wire sia_pkg::sia_pll_status_t i_pll_status,
  input wire sia_pkg::sia_pll_irq_en_t i_pll_irq_en,
  // Summary state
  output logic o_global_irq_flag,
  output logic o_boot_load_finished
);

  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [3:0] pin_meta_ff;
  logic [3:0] pin_level_ff;
  logic [3:0] pin_prev_ff;
  logic [1:0] pin_fill_ff;
  logic [3:0] pin_change_seen_ff;
  logic [3:0] pin_change_irq_en_ff;
  logic global_irq_gate_ff;
  logic boot_load_finished_ff;
  logic pll_ref_low_seen_ff;
  logic pll_ref_high_seen_ff;
  logic pll_lock_change_seen_ff;
  logic pll_ref_low_prev_ff;
  logic pll_ref_high_prev_ff;
  logic pll_locked_prev_ff;
  logic [7:0] o_reg_rdata_ff;
  logic o_reg_rvalid_ff;
  logic [3:0] o_pin_follow_bit_ff;
  logic o_global_irq_flag_ff;
  sia_pkg::sia_reg_req_t req;
  logic wr_en;
  logic rd_en;
  logic [3:0] in_clk_irq;
  logic [9:0] out_clk_irq;
  logic synth_pll_irq;
  logic out_clk_irq_summary;
  logic in_clk_irq_summary;
  logic synth_pll_irq_summary;
  logic global_irq_flag;
  logic [3:0] pin_change_event;
  localparam int STATUS_SPAN_L = sia_pkg::STATUS_SPAN;
  logic [7:0] status_byte [STATUS_SPAN_L];

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // The boot controller owns the bus while it configures; host requests are dropped
  always_comb begin
    req = i_autocfg_busy ? i_boot_req : i_host_req;
    wr_en = req.wr;
    rd_en = req.rd;
  end

  // Pin levels: two-flop sync, then raw level with no inversion applied
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_ff <= sia_pkg::NIBBLE_RESET;
      pin_level_ff <= sia_pkg::NIBBLE_RESET;
      pin_prev_ff <= sia_pkg::NIBBLE_RESET;
      pin_fill_ff <= 2'h0;
    end else begin
      pin_meta_ff <= i_pin_level;
      pin_level_ff <= pin_meta_ff;
      pin_prev_ff <= pin_level_ff;
      pin_fill_ff <= {pin_fill_ff[0], 1'b1};
    end
  end

  // Detection waits two cycles for the sync chain to fill, but pin_prev_ff still holds its reset value then, so a pin high at release sets its change latch
  assign pin_change_event = pin_fill_ff[1] ? (pin_level_ff ^ pin_prev_ff) : 4'h0;

  // Change latches: an edge in the cycle of a clearing write keeps the latch set
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_change_seen_ff <= sia_pkg::NIBBLE_RESET;
    end else begin
      if (wr_en && req.addr == sia_pkg::PIN_STATUS_OFS) begin
        pin_change_seen_ff <= (pin_change_seen_ff & ~req.wdata[7:4]) | pin_change_event;
      end else begin
        pin_change_seen_ff <= pin_change_seen_ff | pin_change_event;
      end
    end
  end

  // Writable control bits
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      global_irq_gate_ff <= 1'b0;
      pin_change_irq_en_ff <= sia_pkg::NIBBLE_RESET;
    end else begin
      if (wr_en && req.addr == sia_pkg::IRQ_SUMMARY_OFS) begin
        global_irq_gate_ff <= req.wdata[sia_pkg::SUM_GATE_BIT];
      end
      if (wr_en && req.addr == sia_pkg::GLOBAL_FN_IRQ_OFS) begin
        pin_change_irq_en_ff <= req.wdata[3:0];
      end
    end
  end

  // Boot finished flag
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      boot_load_finished_ff <= 1'b0;
    end else if (i_boot_done) begin
      boot_load_finished_ff <= 1'b1;
    end
  end

  // PLL latches; set wins over a write-one clear in the same cycle
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pll_ref_low_prev_ff <= 1'b0;
      pll_ref_high_prev_ff <= 1'b0;
      pll_locked_prev_ff <= 1'b0;
      pll_ref_low_seen_ff <= 1'b0;
      pll_ref_high_seen_ff <= 1'b0;
      pll_lock_change_seen_ff <= 1'b0;
    end else begin
      pll_ref_low_prev_ff <= i_pll_status.ref_low_now;
      pll_ref_high_prev_ff <= i_pll_status.ref_high_now;
      pll_locked_prev_ff <= i_pll_status.locked_now;
      pll_ref_low_seen_ff <= (pll_ref_low_seen_ff & ~(wr_en && req.addr == sia_pkg::SYNTH_PLL_STATUS_OFS
        && req.wdata[sia_pkg::PLL_REF_LOW_SEEN_BIT])) | (i_pll_status.ref_low_now & ~pll_ref_low_prev_ff);
      pll_ref_high_seen_ff <= (pll_ref_high_seen_ff & ~(wr_en && req.addr == sia_pkg::SYNTH_PLL_STATUS_OFS
        && req.wdata[sia_pkg::PLL_REF_HIGH_SEEN_BIT])) | (i_pll_status.ref_high_now & ~pll_ref_high_prev_ff);
      pll_lock_change_seen_ff <= (pll_lock_change_seen_ff & ~(wr_en && req.addr == sia_pkg::SYNTH_PLL_STATUS_OFS
        && req.wdata[sia_pkg::PLL_LOCK_SEEN_BIT])) | (i_pll_status.locked_now ^ pll_locked_prev_ff);
    end
  end

  // Group and summary bits, all combinational from present latches and enables
  always_comb begin
    in_clk_irq = i_in_clk.valid_change_seen & i_in_clk.irq_en;
    for (int i = 0; i < 10; i++) begin
      out_clk_irq[i] = |(i_out_clk.seen[i] & i_out_clk.irq_en[i]);
    end
    synth_pll_irq = (pll_ref_low_seen_ff & i_pll_irq_en.ref_low) | (pll_ref_high_seen_ff & i_pll_irq_en.ref_high)
      | (pll_lock_change_seen_ff & i_pll_irq_en.lock);
    out_clk_irq_summary = |out_clk_irq[7:0];
    in_clk_irq_summary = |in_clk_irq;
    synth_pll_irq_summary = synth_pll_irq;
    global_irq_flag = ((out_clk_irq_summary | in_clk_irq_summary | synth_pll_irq_summary) & global_irq_gate_ff)
      | |(pin_change_seen_ff & pin_change_irq_en_ff);
  end

  // Readable image of 0x40..0x48; 0x40 belongs elsewhere and reads zero here
  always_comb begin
    status_byte[0] = 8'h00;
    status_byte[1] = {pin_change_seen_ff, pin_level_ff};
    status_byte[2] = {2'h0, out_clk_irq_summary, in_clk_irq_summary, 1'b0, synth_pll_irq_summary,
      global_irq_gate_ff, global_irq_flag};
    status_byte[3] = {boot_load_finished_ff, 3'h0, pin_change_irq_en_ff};
    status_byte[4] = {4'h0, in_clk_irq};
    status_byte[5] = out_clk_irq[7:0];
    status_byte[6] = {6'h00, out_clk_irq[9:8]};
    status_byte[7] = {7'h00, synth_pll_irq};
    status_byte[8] = {pll_ref_low_seen_ff, i_pll_status.ref_low_now, pll_ref_high_seen_ff,
      i_pll_status.ref_high_now, pll_lock_change_seen_ff, i_pll_status.locked_now, 1'b0,
      i_pll_status.ref_sel};
  end

  // Register read answer one cycle after the request
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata_ff <= sia_pkg::REG_RESET;
      o_reg_rvalid_ff <= 1'b0;
    end else begin
      o_reg_rvalid_ff <= rd_en;
      if (rd_en) begin
        if (req.addr >= sia_pkg::STATUS_BASE && req.addr <= sia_pkg::SYNTH_PLL_STATUS_OFS) begin
          o_reg_rdata_ff <= status_byte[4'(req.addr - sia_pkg::STATUS_BASE)];
        end else begin
          o_reg_rdata_ff <= sia_pkg::REG_RESET;
        end
      end
    end
  end

  // Pin follow: the selected bit, registered alongside the global flag output
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_pin_follow_bit_ff <= sia_pkg::NIBBLE_RESET;
      o_global_irq_flag_ff <= 1'b0;
    end else begin
      o_global_irq_flag_ff <= global_irq_flag;
      for (int p = 0; p < 4; p++) begin
        // Pin status cannot be followed; unimplemented locations drive low
        if (i_pin_follow_select[p][7:3] < 5'(STATUS_SPAN_L) && i_pin_follow_select[p][7:3] != 5'h01) begin
          o_pin_follow_bit_ff[p] <= status_byte[4'(i_pin_follow_select[p][7:3])][i_pin_follow_select[p][2:0]];
        end else begin
          o_pin_follow_bit_ff[p] <= 1'b0;
        end
      end
    end
  end

  assign o_reg_rdata = o_reg_rdata_ff;
  assign o_reg_rvalid = o_reg_rvalid_ff;
  assign o_pin_follow_bit = o_pin_follow_bit_ff;
  assign o_global_irq_flag = o_global_irq_flag_ff;
  assign o_boot_load_finished = boot_load_finished_ff;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!rst_n);

  sequence pin_edge_s(int p);
    pin_fill_ff[1] && (pin_level_ff[p] != pin_prev_ff[p]);
  endsequence

  sequence host_write_busy_s;
    i_autocfg_busy && i_host_req.wr && !i_boot_req.wr;
  endsequence

  pin_level_sync_a:
    assert property ($past(i_pin_level, 2) == pin_level_ff) else $error("pin level not two cycles behind pin");
  pin_latch_set_a:
    assert property (pin_edge_s(0) |=> pin_change_seen_ff[0]) else $error("pin 0 change latch missed an edge");
  out_summary_a:
    assert property (out_clk_irq_summary == |out_clk_irq[7:0]) else $error("output summary wrong");
  gate_blocks_a:
    assert property (!global_irq_gate_ff && !(|(pin_change_seen_ff & pin_change_irq_en_ff)) |-> !global_irq_flag)
      else $error("flag set with gate closed");
  flag_sources_a:
    assert property (global_irq_gate_ff && (in_clk_irq_summary || synth_pll_irq_summary) |=> o_global_irq_flag)
      else $error("gated source did not reach flag");
  pin_irq_flag_a:
    assert property (pin_change_seen_ff[3] && pin_change_irq_en_ff[3] |-> global_irq_flag)
      else $error("enabled pin latch did not set flag");
  boot_done_a:
    assert property (i_boot_done |=> o_boot_load_finished [*3]) else $error("boot finished not held");
  busy_write_a:
    assert property (host_write_busy_s |=> $stable(pin_change_irq_en_ff) && $stable(global_irq_gate_ff))
      else $error("host write took effect while busy");
  ref_low_latch_a:
    assert property ($rose(i_pll_status.ref_low_now) |=> pll_ref_low_seen_ff) else $error("reference low latch missed");
  lock_latch_a:
    assert property ($changed(i_pll_status.locked_now) |=> pll_lock_change_seen_ff) else $error("lock latch missed");
  hi_reserved_a:
    assert property (rd_en && req.addr == sia_pkg::OUT_CLK_IRQ_HI_OFS |=> o_reg_rvalid && o_reg_rdata[7:2] == 6'h00)
      else $error("reserved bits not zero");
  ref_high_latch_a:
    assert property ($rose(i_pll_status.ref_high_now) |=> pll_ref_high_seen_ff)
      else $error("reference high latch missed");
  pin_clear_a:
    assert property (wr_en && req.addr == sia_pkg::PIN_STATUS_OFS && req.wdata[sia_pkg::PIN_SEEN_LSB]
      && !pin_change_event[0] |=> !pin_change_seen_ff[0]) else $error("pin 0 change latch not cleared");
  in_summary_a:
    assert property (in_clk_irq_summary == |(i_in_clk.valid_change_seen & i_in_clk.irq_en))
      else $error("input summary wrong");

endmodule

// ### sia_host_model.sv
// Host side of the register port: byte reads and writes as one-cycle request pulses.
// Assumes the caller owns the core clock; requests change only on falling edges.
`timescale 1ns/100ps
module sia_host_model (
  // Clock
  input wire logic i_mclk,
  // Request to the device
  output sia_pkg::sia_reg_req_t o_req
);
  initial o_req = '0;
  // Released lines show the inverse of the last value so a stale address never looks valid
  task automatic send(input logic is_wr, input logic [8:0] addr, input logic [7:0] data);
    @(negedge i_mclk);
    o_req.rd = ~is_wr;
    o_req.wr = is_wr;
    o_req.addr = addr;
    o_req.wdata = data;
    @(negedge i_mclk);
    o_req.rd = 1'b0;
    o_req.wr = 1'b0;
    o_req.addr = ~addr;
    o_req.wdata = ~data;
  endtask
endmodule

// ### sia_status_irq_tb.sv
// Self-checking bench for the status and interrupt aggregator.
// Assumes one core clock; read results are queued by the driver and checked when rvalid pulses.
`timescale 1ns/100ps
module sia_status_irq_tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  sia_pkg::sia_reg_req_t host_req;
  sia_pkg::sia_reg_req_t boot_req;
  logic busy = 1'b0;
  logic bdone = 1'b0;
  logic [7:0] rdata;
  logic rvalid;
  logic [3:0] pins = 4'h0;
  logic [3:0][7:0] fsel = '0;
  logic [3:0] fbit;
  sia_pkg::sia_in_clk_t inclk = '0;
  sia_pkg::sia_out_clk_t outclk = '0;
  sia_pkg::sia_pll_status_t pst = '0;
  sia_pkg::sia_pll_irq_en_t pen = '0;
  logic gflag;
  logic bfin;
  logic [7:0] expq[$];
  int errors = 0;
  int total_checks = 0;
  logic [15:0] lfsr_v = 16'hB382;
  logic [63:0] wide;
  logic [9:0] oc;
  logic [3:0] ic;
  logic g;
  logic f;

  always #4 mclk = ~mclk;

  sia_host_model i_host (.i_mclk(mclk), .o_req(host_req));
  sia_host_model i_boot (.i_mclk(mclk), .o_req(boot_req));

  sia_status_irq i_dut (
    .i_mclk(mclk), .i_resetn(resetn), .i_host_req(host_req), .i_boot_req(boot_req),
    .i_autocfg_busy(busy), .i_boot_done(bdone), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_pin_level(pins), .i_pin_follow_select(fsel), .o_pin_follow_bit(fbit), .i_in_clk(inclk),
    .i_out_clk(outclk), .i_pll_status(pst), .i_pll_irq_en(pen), .o_global_irq_flag(gflag),
    .o_boot_load_finished(bfin)
  );

  task automatic nrand(output logic [15:0] r);
    lfsr_v = {lfsr_v[14:0], lfsr_v[15] ^ lfsr_v[13] ^ lfsr_v[12] ^ lfsr_v[10]};
    r = lfsr_v;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    expq.push_back(e);
    i_host.send(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    i_host.send(1'b1, a, d);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic complete_run;
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A read answer with no note pending is a refused request that answered anyway
  // Sampled mid-cycle so the registered answer has settled
  always @(negedge mclk) begin
    if (rvalid === 1'b1) begin
      if (expq.size() == 0) begin
        errors++;
        $display("BAD rdata expected none seen %h", rdata);
      end else begin
        chk("rdata", expq.pop_front(), rdata);
      end
    end
  end

  initial begin
    #(8 * 5000);
    errors++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    cyc(4);
    for (int a = 9'h040; a <= 9'h048; a++) rd(a[8:0], 8'h00);
    rd(9'h1FF, 8'h00);
    nrand(wide[15:0]);
    pins = wide[3:0] | 4'h1;
    cyc(5);
    rd(9'h041, {pins, pins});
    wr(9'h041, 8'hF0);
    rd(9'h041, {4'h0, pins});
    pins = ~pins;
    cyc(5);
    rd(9'h042, 8'h00);
    wr(9'h043, 8'h01);
    rd(9'h042, 8'h01);
    cyc(2);
    chk("global flag", 8'h01, {7'h0, gflag});
    wr(9'h041, 8'h10);
    rd(9'h042, 8'h00);
    wr(9'h043, 8'h00);
    fsel[1] = 8'h10;
    for (int i = 0; i < 8; i++) begin
      nrand(wide[63:48]);
      nrand(wide[47:32]);
      nrand(wide[31:16]);
      nrand(wide[15:0]);
      outclk = wide[59:0];
      inclk = wide[63:56] ^ wide[7:0];
      g = wide[i];
      for (int k = 0; k < 10; k++) oc[k] = |(outclk.seen[k] & outclk.irq_en[k]);
      ic = inclk.valid_change_seen & inclk.irq_en;
      f = g & ((|oc[7:0]) | (|ic));
      wr(9'h042, g ? 8'hFF : 8'hFD);
      rd(9'h044, {4'h0, ic});
      rd(9'h045, oc[7:0]);
      rd(9'h046, {6'h0, oc[9:8]});
      rd(9'h042, {2'b00, |oc[7:0], |ic, 2'b00, g, f});
      cyc(2);
      chk("follow flag", {7'h0, f}, {7'h0, fbit[1]});
    end
    inclk = '0;
    outclk = '0;
    wr(9'h042, 8'hFD);
    pst.ref_low_now = 1'b1;
    cyc(3);
    rd(9'h048, 8'hC0);
    rd(9'h047, 8'h00);
    pen.ref_low = 1'b1;
    rd(9'h047, 8'h01);
    rd(9'h042, 8'h04);
    wr(9'h048, 8'h80);
    rd(9'h048, 8'h40);
    pst.ref_low_now = 1'b0;
    pst.locked_now = 1'b1;
    pen.lock = 1'b1;
    wr(9'h042, 8'hFF);
    cyc(2);
    rd(9'h042, 8'h07);
    wr(9'h048, 8'h08);
    rd(9'h048, 8'h04);
    pst.locked_now = 1'b0;
    pst.ref_high_now = 1'b1;
    pst.ref_sel = 1'b1;
    cyc(3);
    rd(9'h048, 8'h39);
    fsel[0] = 8'h1F;
    busy = 1'b1;
    wr(9'h043, 8'h08);
    i_host.send(1'b0, 9'h043, 8'h00);
    i_boot.send(1'b1, 9'h043, 8'h04);
    @(negedge mclk) bdone = 1'b1;
    @(negedge mclk) bdone = 1'b0;
    busy = 1'b0;
    cyc(3);
    chk("boot flag", 8'h01, {7'h0, bfin});
    chk("follow boot", 8'h01, {7'h0, fbit[0]});
    rd(9'h043, 8'h84);
    wr(9'h043, 8'h0C);
    rd(9'h043, 8'h8C);
    cyc(5);
    chk("pending reads", 8'h00, 8'(expq.size()));
    resetn = 1'b0;
    cyc(2);
    chk("boot flag reset", 8'h00, {7'h0, bfin});
    complete_run();
  end
endmodule
